// ### rts_consts.svh
// Constants for the reset time-out sequencer
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH
`define RTS_CLK_PERIOD_NS 10
`define RTS_POWER_UP_TIMER_MS 72
`define RTS_PLL_MS 2
`define RTS_POR_DELAY_NS 1000
`define RTS_BOR_QUAL_NS 200
`define RTS_OST_CYCLES 1024
`define RTS_A_RESET_CAUSE_STATUS 2'h0
`define RTS_A_CFG 2'h1
`define RTS_A_STAT 2'h2
`define RTS_B_IRQ_PRIORITY_EN 7
`define RTS_B_RI 4
`define RTS_B_TO 3
`define RTS_B_PD 2
`define RTS_B_POR 1
`define RTS_B_BOR 0
`define RTS_RESET_CAUSE_STATUS_MASK 8'h9f
`define RTS_RESET_CAUSE_STATUS_RST 8'h1c
`define RTS_CFG_RST 4'h1
`define RTS_C_BROWNOUT_RESET_EN 0
`define RTS_C_PWRTDIS 1
`define RTS_C_MODE_HI 3
`define RTS_C_MODE_LO 2
`define RTS_VEC_RESET 21'h00_0000
`define RTS_VEC_HIGH 21'h00_0008
`define RTS_VEC_LOW 21'h00_0018
`define RTS_PC_STEP 21'h00_0002
`endif

// ### rts_pkg.sv
// Types shared by the reset time-out sequencer
package rts_pkg;
  typedef enum logic [1:0] {OSC_RC, OSC_EC, OSC_XTAL, OSC_PLL} rts_osc_t;
  typedef enum logic [3:0] {
    ST_START, ST_POR_DELAY, ST_BOR_HOLD, ST_POWER_UP_TIMER, ST_OST, ST_PLL,
    ST_RELEASE, ST_RUN, ST_SLEEP
  } rts_state_t;
endpackage : rts_pkg

// ### rts_timer_if.sv
// Load and done handshake between sequencer and delay timer
`timescale 1ns/1ps
interface rts_timer_if #(parameter int TW = 24);
  logic load;
  logic [TW-1:0] loadVal;
  logic tick;
  logic done;
  modport ctrl (output load, output loadVal, output tick, input done);
  modport timer (input load, input loadVal, input tick, output done);
endinterface : rts_timer_if

// ### rts_timer.sv
// Shared down-counter for all reset delays
`timescale 1ns/1ps
module rts_timer #(
  parameter int TW = 24
) (
  input wire logic clk,
  input wire logic rst,
  rts_timer_if.timer tmr
);
  logic [TW-1:0] cntReg;
  logic [TW-1:0] cntNext;

  // Load wins over counting so a restarted delay always runs in full
  assign cntNext = tmr.load ? tmr.loadVal :
                   (tmr.tick && cntReg != '0) ? cntReg - TW'(1) : cntReg;
  assign tmr.done = (cntReg == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cntReg <= '0;
    end else begin
      cntReg <= cntNext;
    end
  end
endmodule : rts_timer

// ### rts_reset_sequencer.sv
// Reset time-out sequencer with reset-cause status register
// Overview of operation
// - With PLL mode, add a 2 ms lock delay after oscillator start-up.
// - Brown-out enable bit clear disables brown-out reset; set enables.
// - Outside the power-up timer, brown-out resets only if low supply lasts beyond qualification.
// - Hold reset while supply low, then run power-up timer.
// - Supply dip during power-up timer returns to hold and restarts it.
// - Power-up order: power-on delay, power-up timer, oscillator count.
// - RC mode with power-up timer disabled has no time-out.
// - Delays run from power-on even with master clear held low.
// - PLL crystal totals timer plus 1024 periods plus 2 ms.
// - Power-up timer is 72 ms, only on power-up or brown-out.
// - Status: bit 7 priority enable, 6:5 unused, 4:0 cause flags.
// - Power-on and brown-out set their documented flag patterns.
// - Resets restart at zero; master clear clears priority enable.
// - Software reset clears its flag and priority enable.
// - Stack fault sets power-on, brown-out and its own stack flag.
// - Time-out and power-down flags encode sleep and watchdog causes.
// - Wake-up resumes at next instruction or an interrupt vector.
// - Oscillator start-up counts 1024 oscillator input cycles.
// - Oscillator count only in crystal modes.
`timescale 1ns/1ps
`include "rts_consts.svh"
module rts_reset_sequencer #(
  parameter int TW = 24,
  parameter int QW = 8,
  parameter int POWER_UP_TIMER_CYCLES = `RTS_POWER_UP_TIMER_MS * 1000000 / `RTS_CLK_PERIOD_NS,
  parameter int PLL_CYCLES = `RTS_PLL_MS * 1000000 / `RTS_CLK_PERIOD_NS,
  parameter int POR_DELAY_CYCLES =
    (`RTS_POR_DELAY_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS,
  parameter int BOR_QUAL_CYCLES =
    (`RTS_BOR_QUAL_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS,
  parameter int OST_COUNT = `RTS_OST_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterClearN,
  input wire logic brownoutDetect,
  input wire logic oscInputPin,
  input wire logic wdtTimeout,
  input wire logic swResetReq,
  input wire logic stackOverflowReq,
  input wire logic stackUnderflowReq,
  input wire logic sleepReq,
  input wire logic irqWake,
  input wire logic irqIsHigh,
  input wire logic highPrioGlobalIrqEn,
  input wire logic lowPrioGlobalIrqEn,
  input wire logic [20:0] pcIn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic deviceReset,
  output logic coreHold,
  output logic restartValid,
  output logic [20:0] restartAddr,
  output logic irqPriorityEn
);
  if (POWER_UP_TIMER_CYCLES >= 2 ** TW || PLL_CYCLES >= 2 ** TW ||
      POR_DELAY_CYCLES >= 2 ** TW || OST_COUNT >= 2 ** TW) begin : g_chk_t
    $error("Timer width too small for a delay count");
  end
  if (BOR_QUAL_CYCLES < 1 || BOR_QUAL_CYCLES >= 2 ** QW) begin : g_chk_q
    $error("Brown-out qualification count out of range");
  end

  localparam logic [TW-1:0] PwrtLoad = TW'(POWER_UP_TIMER_CYCLES);
  localparam logic [TW-1:0] PllLoad = TW'(PLL_CYCLES);
  localparam logic [TW-1:0] PorLoad = TW'(POR_DELAY_CYCLES);
  localparam logic [TW-1:0] OstLoad = TW'(OST_COUNT);
  localparam logic [QW-1:0] QualMax = QW'(BOR_QUAL_CYCLES);

  // Pin synchronisers; only the second stage is ever read
  logic [2:0] pinsAsync;
  logic [2:0] pinsSync;
  assign pinsAsync = {oscInputPin, brownoutDetect, masterClearN};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic s1Reg;
    logic s2Reg;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1Reg <= 1'b0;
        s2Reg <= 1'b0;
      end else begin
        s1Reg <= pinsAsync[i];
        s2Reg <= s1Reg;
      end
    end
    assign pinsSync[i] = s2Reg;
  end

  logic mclrHigh;
  logic borBelow;
  logic oscLvl;
  logic oscPrevReg;
  logic oscRise;
  assign mclrHigh = pinsSync[0];
  assign borBelow = pinsSync[1];
  assign oscLvl = pinsSync[2];
  assign oscRise = oscLvl & ~oscPrevReg;

  rts_pkg::rts_state_t stateReg;
  rts_pkg::rts_state_t stateNext;
  logic [7:0] rconReg;
  logic [7:0] rconNext;
  logic [3:0] cfgReg;
  logic [1:0] stkReg;
  logic [1:0] stkNext;
  logic [QW-1:0] qualReg;
  logic [20:0] pendReg;
  logic [20:0] pendNext;
  logic wakeReg;
  logic wakeNext;
  logic [7:0] rdMux;
  logic [7:0] statView;

  // Register decode
  logic rconWr;
  logic cfgWr;
  logic statWr;
  assign rconWr = regWr && regAddr == `RTS_A_RESET_CAUSE_STATUS;
  assign cfgWr = regWr && regAddr == `RTS_A_CFG;
  assign statWr = regWr && regAddr == `RTS_A_STAT;

  // Configuration fields
  logic brownout_reset_en;
  logic pwrtOn;
  rts_pkg::rts_osc_t oscMode;
  assign brownout_reset_en = cfgReg[`RTS_C_BROWNOUT_RESET_EN];
  assign pwrtOn = ~cfgReg[`RTS_C_PWRTDIS];
  assign oscMode =
    rts_pkg::rts_osc_t'(cfgReg[`RTS_C_MODE_HI:`RTS_C_MODE_LO]);

  // Crystal modes need the start-up count; RC and EC go straight on
  function automatic rts_pkg::rts_state_t afterPwrt(
    input rts_pkg::rts_osc_t m
  );
    if (m == rts_pkg::OSC_XTAL || m == rts_pkg::OSC_PLL) begin
      afterPwrt = rts_pkg::ST_OST;
    end else begin
      afterPwrt = rts_pkg::ST_RELEASE;
    end
  endfunction : afterPwrt

  function automatic logic [TW-1:0] loadFor(input rts_pkg::rts_state_t s);
    case (s)
      rts_pkg::ST_POR_DELAY: loadFor = PorLoad;
      rts_pkg::ST_POWER_UP_TIMER: loadFor = PwrtLoad;
      rts_pkg::ST_OST: loadFor = OstLoad;
      rts_pkg::ST_PLL: loadFor = PllLoad;
      default: loadFor = '0;
    endcase
  endfunction : loadFor

  // Events
  logic inRun;
  logic inSleep;
  logic borLow;
  logic borQualified;
  logic evBor;
  logic [20:0] wakeAddr;
  assign inRun = stateReg == rts_pkg::ST_RUN;
  assign inSleep = stateReg == rts_pkg::ST_SLEEP;
  assign borLow = brownout_reset_en && borBelow;
  // Needs more than the qualification count of low cycles
  assign borQualified = borLow && qualReg == QualMax;
  // Inside the power-up timer any dip counts, unqualified
  assign evBor = stateReg != rts_pkg::ST_BOR_HOLD &&
                 (borQualified ||
                  (borLow && stateReg == rts_pkg::ST_POWER_UP_TIMER));
  assign wakeAddr =
    (irqWake && irqIsHigh && highPrioGlobalIrqEn) ? `RTS_VEC_HIGH :
    (irqWake && !irqIsHigh && lowPrioGlobalIrqEn) ? `RTS_VEC_LOW :
    pcIn + `RTS_PC_STEP;

  // Timer
  rts_timer_if #(.TW(TW)) tmrBus();
  assign tmrBus.load = stateNext != stateReg;
  assign tmrBus.loadVal = loadFor(stateNext);
  assign tmrBus.tick = stateReg == rts_pkg::ST_OST ? oscRise : 1'b1;

  rts_timer #(.TW(TW)) u_timer (
    .clk(clk),
    .rst(rst),
    .tmr(tmrBus)
  );

  always_comb begin
    stateNext = stateReg;
    pendNext = pendReg;
    wakeNext = wakeReg;
    // Software writes first; hardware events below override them
    rconNext = rconWr ? (regWdata & `RTS_RESET_CAUSE_STATUS_MASK) : rconReg;
    stkNext = statWr ? regWdata[1:0] : stkReg;
    if (evBor) begin
      stateNext = rts_pkg::ST_BOR_HOLD;
      pendNext = `RTS_VEC_RESET;
      wakeNext = 1'b0;
      rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
      rconNext[`RTS_B_RI] = 1'b1;
      rconNext[`RTS_B_TO] = 1'b1;
      rconNext[`RTS_B_PD] = 1'b1;
      rconNext[`RTS_B_BOR] = 1'b0;
    end else begin
      case (stateReg)
        rts_pkg::ST_START: begin
          stateNext = rts_pkg::ST_POR_DELAY;
        end
        rts_pkg::ST_POR_DELAY: begin
          if (tmrBus.done) begin
            stateNext = pwrtOn ? rts_pkg::ST_POWER_UP_TIMER : afterPwrt(oscMode);
          end
        end
        rts_pkg::ST_BOR_HOLD: begin
          if (!borLow) begin
            stateNext = pwrtOn ? rts_pkg::ST_POWER_UP_TIMER : afterPwrt(oscMode);
          end
        end
        rts_pkg::ST_POWER_UP_TIMER: begin
          if (tmrBus.done) begin
            stateNext = afterPwrt(oscMode);
          end
        end
        rts_pkg::ST_OST: begin
          if (tmrBus.done) begin
            stateNext = oscMode == rts_pkg::OSC_PLL ?
                        rts_pkg::ST_PLL : rts_pkg::ST_RELEASE;
          end
        end
        rts_pkg::ST_PLL: begin
          if (tmrBus.done) begin
            stateNext = rts_pkg::ST_RELEASE;
          end
        end
        rts_pkg::ST_RELEASE: begin
          // Delays already ran; the pin alone now gates start
          if (mclrHigh) begin
            stateNext = rts_pkg::ST_RUN;
          end
        end
        rts_pkg::ST_RUN: begin
          if (!mclrHigh) begin
            stateNext = rts_pkg::ST_RELEASE;
            pendNext = `RTS_VEC_RESET;
            rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
          end else if (stackOverflowReq || stackUnderflowReq) begin
            stateNext = rts_pkg::ST_RELEASE;
            pendNext = `RTS_VEC_RESET;
            rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
            rconNext[`RTS_B_POR] = 1'b1;
            rconNext[`RTS_B_BOR] = 1'b1;
            stkNext = stkNext | {stackUnderflowReq, stackOverflowReq};
          end else if (wdtTimeout) begin
            stateNext = rts_pkg::ST_RELEASE;
            pendNext = `RTS_VEC_RESET;
            rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
            rconNext[`RTS_B_TO] = 1'b0;
            rconNext[`RTS_B_PD] = 1'b1;
          end else if (swResetReq) begin
            stateNext = rts_pkg::ST_RELEASE;
            pendNext = `RTS_VEC_RESET;
            rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
            rconNext[`RTS_B_RI] = 1'b0;
          end else if (sleepReq) begin
            stateNext = rts_pkg::ST_SLEEP;
          end
        end
        rts_pkg::ST_SLEEP: begin
          if (!mclrHigh) begin
            stateNext = rts_pkg::ST_RELEASE;
            pendNext = `RTS_VEC_RESET;
            rconNext[`RTS_B_IRQ_PRIORITY_EN] = 1'b0;
            rconNext[`RTS_B_TO] = 1'b1;
            rconNext[`RTS_B_PD] = 1'b0;
          end else if (wdtTimeout || irqWake) begin
            // Wake skips the power-up timer, never resets the core
            stateNext = afterPwrt(oscMode);
            pendNext = wdtTimeout ? pcIn + `RTS_PC_STEP : wakeAddr;
            wakeNext = 1'b1;
            rconNext[`RTS_B_TO] = ~wdtTimeout;
            rconNext[`RTS_B_PD] = 1'b0;
          end
        end
        default: begin
          stateNext = rts_pkg::ST_START;
        end
      endcase
      if (stateNext == rts_pkg::ST_RUN) begin
        wakeNext = 1'b0;
      end
      if (stateReg == rts_pkg::ST_RUN && stateNext == rts_pkg::ST_RELEASE) begin
        wakeNext = 1'b0;
      end
    end
  end

  // Read path
  assign statView = {4'h0, borBelow, deviceReset, stkReg};
  assign rdMux = regAddr == `RTS_A_RESET_CAUSE_STATUS ? rconReg :
                 regAddr == `RTS_A_CFG ? {4'h0, cfgReg} :
                 regAddr == `RTS_A_STAT ? statView : 8'h00;

  logic runNext;
  assign runNext = stateNext == rts_pkg::ST_RUN ||
                   stateNext == rts_pkg::ST_SLEEP;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= rts_pkg::ST_START;
      rconReg <= `RTS_RESET_CAUSE_STATUS_RST;
      cfgReg <= `RTS_CFG_RST;
      stkReg <= 2'h0;
      pendReg <= `RTS_VEC_RESET;
      wakeReg <= 1'b0;
      oscPrevReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      rconReg <= rconNext;
      cfgReg <= cfgWr ? regWdata[3:0] : cfgReg;
      stkReg <= stkNext;
      pendReg <= pendNext;
      wakeReg <= wakeNext;
      oscPrevReg <= oscLvl;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qualReg <= '0;
    end else if (!borLow) begin
      qualReg <= '0;
    end else if (qualReg != QualMax) begin
      qualReg <= qualReg + QW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
      deviceReset <= 1'b1;
      coreHold <= 1'b0;
      restartValid <= 1'b0;
      restartAddr <= `RTS_VEC_RESET;
    end else begin
      regRdata <= regRd ? rdMux : 8'h00;
      deviceReset <= !runNext && !wakeNext;
      coreHold <= !runNext && wakeNext;
      restartValid <= stateReg == rts_pkg::ST_RELEASE &&
                      stateNext == rts_pkg::ST_RUN;
      restartAddr <= stateNext == rts_pkg::ST_RUN &&
                     stateReg == rts_pkg::ST_RELEASE ?
                     pendReg : restartAddr;
    end
  end

  assign irqPriorityEn = rconReg[`RTS_B_IRQ_PRIORITY_EN];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_bor_off;
    !brownout_reset_en |=> qualReg == '0;
  endproperty
  a_bor_off: assert property (p_bor_off)
    else $error("Qualifier counted while brown-out disabled");

  property p_bor_flags;
    evBor |=> stateReg == rts_pkg::ST_BOR_HOLD && !rconReg[0] &&
              rconReg[4] && rconReg[3] && rconReg[2] && !rconReg[7];
  endproperty
  a_bor_flags: assert property (p_bor_flags)
    else $error("Brown-out entry flags wrong");

  property p_power_up_timer_dip;
    stateReg == rts_pkg::ST_POWER_UP_TIMER && borLow |=>
      stateReg == rts_pkg::ST_BOR_HOLD;
  endproperty
  a_power_up_timer_dip: assert property (p_power_up_timer_dip)
    else $error("Supply dip did not restart power-up timer");

  property p_pll_done;
    stateReg == rts_pkg::ST_PLL && !tmrBus.done && !evBor |=>
      stateReg == rts_pkg::ST_PLL;
  endproperty
  a_pll_done: assert property (p_pll_done)
    else $error("Lock delay ended early");

  property p_master_clear_n_go;
    stateReg == rts_pkg::ST_RELEASE && mclrHigh && !evBor |=>
      stateReg == rts_pkg::ST_RUN && restartValid;
  endproperty
  a_master_clear_n_go: assert property (p_master_clear_n_go)
    else $error("Release did not start execution at once");

  property p_sw_reset;
    inRun && mclrHigh && swResetReq && !wdtTimeout && !evBor &&
    !stackOverflowReq && !stackUnderflowReq |=>
      !rconReg[4] && !rconReg[7];
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("Software reset flags wrong");

  property p_wdt_reset;
    inRun && mclrHigh && wdtTimeout && !evBor &&
    !stackOverflowReq && !stackUnderflowReq |=>
      !rconReg[3] && rconReg[2] && deviceReset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("Watchdog reset flags wrong");

  property p_rc_none;
    stateReg == rts_pkg::ST_POR_DELAY && tmrBus.done && !pwrtOn &&
    oscMode == rts_pkg::OSC_RC && !evBor |=>
      stateReg == rts_pkg::ST_RELEASE;
  endproperty
  a_rc_none: assert property (p_rc_none)
    else $error("RC mode applied a time-out");

  property p_restart_zero;
    restartValid && !$past(wakeReg) |-> restartAddr == `RTS_VEC_RESET;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("Reset restart address not zero");
endmodule : rts_reset_sequencer

// ### rts_supply_model.sv
// Supply monitor, master clear pin and main oscillator model
`timescale 1ns/1ps
module rts_supply_model #(
  parameter int OSC_HALF = 3
) (
  input wire logic clk,
  output logic masterClearN,
  output logic brownoutDetect,
  output logic oscInputPin
);
  int oscCnt;
  initial begin
    masterClearN = 1'h1;
    brownoutDetect = 1'h0;
    oscInputPin = 1'h0;
    oscCnt = 0;
  end
  // Crystal keeps running; a stopped input would stall the start-up count
  always @(posedge clk) begin
    oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
    if (oscCnt == OSC_HALF - 1) oscInputPin <= ~oscInputPin;
  end
  // Supply below threshold for n cycles, then back up
  task automatic dip(input int n);
    @(posedge clk) brownoutDetect <= 1'h1;
    repeat (n) @(posedge clk);
    brownoutDetect <= 1'h0;
  endtask : dip
  // Pin stays at this level until set again
  task automatic set_clear(input logic v);
    @(posedge clk) masterClearN <= v;
  endtask : set_clear
endmodule : rts_supply_model

// ### reset_timeout_sequencer_bench.sv
// Self-checking bench for the reset time-out sequencer
`timescale 1ns/1ps
`include "rts_consts.svh"
module reset_timeout_sequencer_bench;
  localparam int POWER_UP_TIMER = 50, PLLC = 20, OSTC = 8, PORD = 5, OSCP = 6;
  logic clk = 1'h0, rst = 1'h1, wdtTimeout = 1'h0, swResetReq = 1'h0;
  logic stackOverflowReq = 1'h0, stackUnderflowReq = 1'h0, sleepReq = 1'h0;
  logic irqWake = 1'h0, irqIsHigh = 1'h0, regWr = 1'h0, regRd = 1'h0;
  logic highPrioGlobalIrqEn = 1'h0, lowPrioGlobalIrqEn = 1'h0;
  logic [20:0] pcIn = 21'h00_0000;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, rdv;
  logic masterClearN, brownoutDetect, oscInputPin, deviceReset, coreHold;
  logic restartValid, irqPriorityEn;
  logic [20:0] restartAddr;
  int mismatches = 0, n_tests = 0;

  rts_supply_model #(.OSC_HALF(OSCP / 2)) sup (.clk(clk),
    .masterClearN(masterClearN), .brownoutDetect(brownoutDetect),
    .oscInputPin(oscInputPin));
  // Shortened counts keep each power-up delay between 5 and 123 cycles
  rts_reset_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .PLL_CYCLES(PLLC),
    .OST_COUNT(OSTC), .POR_DELAY_CYCLES(PORD), .BOR_QUAL_CYCLES(3)) uut (
    .clk(clk), .rst(rst), .masterClearN(masterClearN),
    .brownoutDetect(brownoutDetect), .oscInputPin(oscInputPin),
    .wdtTimeout(wdtTimeout), .swResetReq(swResetReq),
    .stackOverflowReq(stackOverflowReq),
    .stackUnderflowReq(stackUnderflowReq), .sleepReq(sleepReq),
    .irqWake(irqWake), .irqIsHigh(irqIsHigh),
    .highPrioGlobalIrqEn(highPrioGlobalIrqEn),
    .lowPrioGlobalIrqEn(lowPrioGlobalIrqEn), .pcIn(pcIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .deviceReset(deviceReset), .coreHold(coreHold),
    .restartValid(restartValid), .restartAddr(restartAddr),
    .irqPriorityEn(irqPriorityEn));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [20:0] e,
                     input logic [20:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 v = regRdata;
  endtask : rd

  task automatic wait_low(output int c);
    c = 0;
    while (deviceReset !== 1'h0 && c < 1000) begin
      @(posedge clk);
      #1 c++;
    end
  endtask : wait_low

  task automatic wait_restart(output logic [20:0] a);
    int c;
    c = 0;
    // The start pulse rises with the same edge that drops deviceReset
    #1;
    while (restartValid !== 1'h1 && c < 1000) begin
      @(posedge clk);
      #1 c++;
    end
    a = restartAddr;
    cmp("restart_seen", 21'h00_0001, restartValid);
  endtask : wait_restart

  function automatic int exp_delay(input logic [3:0] cfg);
    exp_delay = PORD + (cfg[1] ? 0 : POWER_UP_TIMER) + (cfg[3] ? OSTC * OSCP : 0) +
      (cfg[3:2] == 2'h3 ? PLLC : 0);
  endfunction : exp_delay

  function automatic logic [7:0] exp_status(input int k, input logic [7:0] p);
    logic [7:0] s;
    s = p;
    case (k)
      0: begin s[7] = 1'h0; s[4] = 1'h0; end
      1: begin s[7] = 1'h0; s[3:2] = 2'h1; end
      2, 3: begin s[7] = 1'h0; s[1:0] = 2'h3; end
      4: s[7] = 1'h0;
      5: begin s[7] = 1'h0; s[4:2] = 3'h7; s[0] = 1'h0; end
      6, 7, 8: s[3:2] = 2'h2;
      9: s[3:2] = 2'h0;
      default: begin s[7] = 1'h0; s[3:2] = 2'h2; end
    endcase
    return s;
  endfunction : exp_status

  function automatic logic [20:0] exp_addr(input int k, input logic [20:0] pc);
    case (k)
      6: return 21'h00_0008;
      7: return 21'h00_0018;
      8, 9: return pc + 21'h00_0002;
      default: return 21'h00_0000;
    endcase
  endfunction : exp_addr

  task automatic power_up(input logic [3:0] cfg, input logic hold);
    int c;
    logic [20:0] a;
    @(posedge clk) rst <= 1'h1;
    if (hold) sup.set_clear(1'h0);
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    wr(2'h1, {4'h0, cfg});
    if (hold) begin
      // Requests while still held in reset must all be refused
      repeat (exp_delay(cfg) + 40) begin
        @(posedge clk);
        {wdtTimeout, swResetReq, stackOverflowReq, stackUnderflowReq} <=
          4'($urandom);
        {sleepReq, irqWake, irqIsHigh} <= 3'($urandom);
        {highPrioGlobalIrqEn, lowPrioGlobalIrqEn} <= 2'($urandom);
      end
      @(posedge clk);
      {wdtTimeout, swResetReq, stackOverflowReq, stackUnderflowReq} <= 4'h0;
      {sleepReq, irqWake, irqIsHigh} <= 3'h0;
      {highPrioGlobalIrqEn, lowPrioGlobalIrqEn} <= 2'h0;
      #1 cmp("held_by_clear", 21'h00_0001, deviceReset);
      sup.set_clear(1'h1);
      wait_low(c);
      cmp("clear_release_fast", 21'h00_0001, c <= 5);
    end else begin
      wait_low(c);
      c += 2;
      cmp("delay_low", 21'h00_0001, c >= exp_delay(cfg) - OSCP);
      cmp("delay_high", 21'h00_0001, c <= exp_delay(cfg) + 20);
    end
    wait_restart(a);
    cmp("por_addr", 21'h00_0000, a);
    rd(2'h0, rdv);
    cmp("por_status", `RTS_RESET_CAUSE_STATUS_RST, rdv);
  endtask : power_up

  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: swResetReq <= 1'h1;
      1, 9: wdtTimeout <= 1'h1;
      2: stackOverflowReq <= 1'h1;
      3: stackUnderflowReq <= 1'h1;
      5: sup.dip(8);
      6: begin irqWake <= 1'h1; irqIsHigh <= 1'h1; highPrioGlobalIrqEn <= 1'h1; end
      7: begin irqWake <= 1'h1; irqIsHigh <= 1'h0; lowPrioGlobalIrqEn <= 1'h1; end
      8: begin irqWake <= 1'h1; irqIsHigh <= 1'h1; end
      default: begin sup.set_clear(1'h0); repeat (3) @(posedge clk); sup.set_clear(1'h1); end
    endcase
    @(posedge clk);
    {swResetReq, wdtTimeout, stackOverflowReq, stackUnderflowReq} <= 4'h0;
    irqWake <= 1'h0;
  endtask : fire

  task automatic quiet_count(output int n);
    n = 0;
    repeat (12) begin
      @(posedge clk);
      #1 n += (deviceReset !== 1'h0);
    end
  endtask : quiet_count

  initial begin
    logic [7:0] r, e;
    logic [20:0] a;
    logic [1:0] h;
    int c;
    r = 8'($urandom(77));
    for (int i = 0; i < 8; i++) begin
      power_up({i[2:1], i[0], 1'h1}, 1'h0);
    end
    power_up(4'h9, 1'h1);
    wr(2'h0, 8'hff);
    rd(2'h0, r);
    cmp("status_bits", 21'h00_009f, r);
    wr(2'h3, 8'hff);
    rd(2'h3, r);
    cmp("unmapped", 21'h00_0000, r);
    wr(2'h1, 8'h01);
    sup.dip(2);
    quiet_count(c);
    cmp("short_dip", 21'h00_0000, c);
    wr(2'h1, 8'h00);
    sup.dip(30);
    quiet_count(c);
    cmp("bor_disabled", 21'h00_0000, c);
    wr(2'h1, 8'h01);
    sup.dip(30);
    #1 cmp("bor_hold", 21'h00_0001, deviceReset);
    wait_low(c);
    cmp("bor_power_up_timer", 21'h00_0001, c >= POWER_UP_TIMER && c <= POWER_UP_TIMER + 10);
    wait_restart(a);
    sup.dip(10);
    repeat (25) @(posedge clk);
    sup.dip(2);
    wait_low(c);
    cmp("bor_restart", 21'h00_0001, c >= POWER_UP_TIMER && c <= POWER_UP_TIMER + 10);
    wait_restart(a);
    // Random prior flags show which bits each cause really touches
    for (int k = 0; k < 22; k++) begin
      r = 8'($urandom) & 8'h9f;
      @(posedge clk) pcIn <= 21'($urandom) & 21'h0f_fffe;
      wr(2'h0, r);
      wr(2'h2, 8'h00);
      wr(2'h1, {4'h0, 2'($urandom), 2'h1});
      if (k % 11 >= 6) begin
        @(posedge clk) sleepReq <= 1'h1;
        @(posedge clk) sleepReq <= 1'h0;
        repeat (3) @(posedge clk);
      end
      fire(k % 11);
      h = {k % 11 < 6 || k % 11 == 10, k % 11 >= 6 && k % 11 < 10};
      #1 cmp("held", h, {deviceReset, coreHold});
      wait_restart(a);
      {highPrioGlobalIrqEn, lowPrioGlobalIrqEn} <= 2'h0;
      cmp("restart_addr", exp_addr(k % 11, pcIn), a);
      e = exp_status(k % 11, r);
      rd(2'h0, rdv);
      cmp("cause_flags", e, rdv);
      cmp("prio_pin", e[7], irqPriorityEn);
      rd(2'h2, rdv);
      cmp("stack_flags", {k % 11 == 3, k % 11 == 2}, rdv[1:0]);
    end
    tally_and_finish();
  end

  // Tests need under three thousand cycles; this bound is twenty times that
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : reset_timeout_sequencer_bench
